// ### bench/csoc_ctl_model.sv
/*
 Model of the external controller pins around the sense block.
 Assumes pclk; pin levels follow the bench's requests one edge later, drive-time-done one edge after the gate command.
*/
`timescale 1ns/1ps
`default_nettype none
module csoc_ctl_model (
   input  wire logic       pclk,
   input  wire logic       w_cal,
   input  wire logic [2:0] w_hs,
   input  wire logic [2:0] w_sn,
   input  wire logic [2:0] w_gate,
   input  wire logic       flt_o,
   input  wire logic       flt_oe,
   output var  logic       cal_pin,
   output var  logic [2:0] hs_cmp,
   output var  logic [2:0] ls_cmp_sn,
   output var  logic [2:0] ls_gate_cmd,
   output var  logic [2:0] tdrive_done,
   output wire logic       flt
);
   // The fault line has a pull-up, so it reads high when nobody drives it.
   assign flt = flt_oe ? flt_o : 1'b1;
   initial
   begin
      {cal_pin, hs_cmp, ls_cmp_sn, ls_gate_cmd, tdrive_done} = '0;
   end
   always @(posedge pclk)
   begin
      cal_pin     <= w_cal;
      hs_cmp      <= w_hs;
      ls_cmp_sn   <= w_sn;
      ls_gate_cmd <= w_cal ? 3'h0 : w_gate;
      tdrive_done <= w_gate & ls_gate_cmd;
   end
endmodule
`default_nettype wire

// ### bench/test_csoc_top.sv
/*
 Self-checking bench for the sense and overcurrent block.
 Assumes the APB slave answers with pready and the pin model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module test_csoc_top;
   import csoc_pkg::*;
   localparam int TRIM_TB = 20;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        cal_pin, flt_o, flt_oe, shut, lowside_reference_select_sn, vref_bidir, irq, w_cal;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  hs_cmp, ls_cmp_sn, ls_gate_cmd, tdrive_done, trim_run, w_hs, w_sn, w_gate;
   logic [3:0]  trip_threshold;
   wire logic   flt;
   csoc_amp_t   amp;
   int          n_errors, total_checks, n;
   csoc_top #(.TRIM_CYCLES(TRIM_TB)) i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .pready, .prdata, .pslverr, .hs_cmp, .ls_cmp_sp(3'h0), .ls_cmp_sn, .cal_pin,
      .ls_gate_cmd, .tdrive_done, .fault_out_n_i(flt), .fault_out_n_o(flt_o),
      .fault_out_n_oe(flt_oe), .gate_shutdown(shut), .trip_threshold, .lowside_reference_select_sn, .vref_bidir,
      .amp, .trim_run, .irq);
   csoc_ctl_model i_ctl (.pclk, .w_cal, .w_hs, .w_sn, .w_gate, .flt_o, .flt_oe, .cal_pin,
      .hs_cmp, .ls_cmp_sn, .ls_gate_cmd, .tdrive_done, .flt);
   always #5 pclk = ~pclk;
   ////////////////////////////////////////
   task automatic give_verdict();
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic look(input int c);
      repeat (c) @(negedge pclk);
   endtask
   // One transfer: setup, access until pready, release at the sampling edge.
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         if (++k > 20)
         begin
            chk("pready", 32'h0000_0001, 32'h0000_0000);
            give_verdict();
         end
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0000_0000);
      chk(what, exp, rd);
   endtask
   function automatic logic cond(input int s);
      case (s)
         0: return trim_run[0];
         1: return !trim_run[0];
         2: return trim_run == 3'h7;
         3: return trim_run == 3'h0;
         4: return irq;
         default: return shut;
      endcase
   endfunction
   task automatic await(input int s, output int c);
      c = 0;
      while (cond(s) !== 1'b1)
      begin
         look(1);
         if (++c > 600)
         begin
            chk("wait", 32'h0000_0001, 32'h0000_0000);
            give_verdict();
         end
      end
   endtask
   function automatic logic [31:0] cw(input logic [3:0] t, input logic [1:0] m, input logic [2:0] f,
                                      input logic [1:0] g);
      return {21'h0, t, m, f, g};
   endfunction
   ////////////////////////////////////////
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata, w_cal, w_hs, w_sn, w_gate} = '0;
      n_errors = 0;
      total_checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      look(1);
      chk("rst outs", 32'h0020_0000, 32'({lowside_reference_select_sn, vref_bidir, amp, trim_run, irq, shut, flt_oe}));
      chk("rst thr", 32'h0000_0009, 32'(trip_threshold));
      rdc("ctrl", A_CTRL, 32'h0000_0480);
      xfer(8'h18, 1'b0, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, 32'(err));
      wr(A_ISTAT, 32'h0000_01ff);
      rdc("istat", A_ISTAT, 32'h0000_0000);
      wr(A_ICLR, 32'h0000_01ff);
      rdc("iclr", A_ICLR, 32'h0000_0000);
      for (int g = 0; g < 4; g++)
      begin
         wr(A_CTRL, cw(4'(g * 5), FM_LATCH, 3'h0, 2'(g)));
         look(2);
         chk("gain", 32'({3{2'(g)}}), 32'(amp.gain));
         chk("thr", 32'(g * 5), 32'(trip_threshold));
      end
      wr(A_CTRL, cw(4'h9, FM_LATCH, 3'h2, 2'h0));
      look(2);
      chk("ref sn", 32'h0000_0001, 32'(lowside_reference_select_sn));
      wr(A_CTRL, cw(4'h9, FM_LATCH, 3'h4, 2'h0));
      look(4);
      chk("fet ref", 32'h0000_0001, 32'(lowside_reference_select_sn));
      chk("fet short", 32'h0000_0007, 32'(amp.short_in));
      w_gate = 3'h5;
      look(5);
      chk("fet en", 32'h0000_002A, 32'({amp.enable, amp.short_in}));
      w_gate = 3'h0;
      wr(A_CTRL, cw(4'h9, FM_LATCH, 3'h1, 2'h1));
      look(2);
      chk("ref sp", 32'h0000_0000, 32'(lowside_reference_select_sn));
      chk("unidir", 32'h0000_0000, 32'(vref_bidir));
      wr(A_IEN, 32'h0000_0040);
      wr(A_CAL, 32'h0000_0001);
      await(0, n);
      look(1);
      chk("cal amp", 32'h0000_05C9, 32'({amp.gain, amp.short_in, amp.load_off}));
      chk("cal ref", 32'h0000_0001, 32'(vref_bidir));
      await(1, n);
      chk("trim len", TRIM_TB, n + 1);
      wr(A_CTRL, cw(4'h9, FM_LATCH, 3'h1, 2'h0));
      look(2);
      chk("hold amp", 32'h0000_05C9, 32'({amp.gain, amp.short_in, amp.load_off}));
      rdc("trim done", A_ISTAT, 32'h0000_0040);
      chk("irq on", 32'h0000_0001, 32'(irq));
      wr(A_ICLR, 32'h0000_0040);
      look(2);
      chk("irq off", 32'h0000_0000, 32'(irq));
      wr(A_CAL, 32'h0000_0000);
      look(3);
      chk("restore", 32'h0000_0150, 32'({amp.gain, amp.short_in, vref_bidir}));
      w_cal = 1'b1;
      await(2, n);
      look(1);
      chk("pin cal", 32'h0000_01ff, 32'({amp.gain, amp.short_in}));
      await(3, n);
      rdc("pin done", A_ISTAT, 32'h0000_01c0);
      w_cal = 1'b0;
      wr(A_ICLR, 32'h0000_01c0);
      look(3);
      chk("pin end", 32'h0000_0015, 32'(amp.gain));
      wr(A_CTRL, cw(4'h9, FM_REPORT, 3'h2, 2'h1));
      wr(A_IEN, 32'h0000_003f);
      w_sn = 3'h4;
      await(4, n);
      chk("ls delay", 32'h0000_0001, 32'(n >= OCP_CYC));
      rdc("ls trip", A_ISTAT, 32'h0000_0020);
      w_sn = 3'h0;
      wr(A_ICLR, 32'h0000_003f);
      wr(A_CTRL, cw(4'h9, FM_LATCH, 3'h0, 2'h1));
      w_hs = 3'h2;
      look(OCP_CYC / 2);
      w_hs = 3'h0;
      look(4);
      chk("glitch", 32'h0000_0000, 32'({shut, irq}));
      w_hs = 3'h2;
      w_sn = 3'h7;
      await(5, n);
      chk("hs delay", 32'h0000_0001, 32'(n >= OCP_CYC && n <= OCP_CYC + 8));
      w_hs = 3'h0;
      w_sn = 3'h0;
      look(3);
      chk("latched", 32'h0000_0003, 32'({shut, flt_oe}));
      rdc("state", A_STATE, 32'h0000_0040);
      rdc("hs trip", A_ISTAT, 32'h0000_0002);
      give_verdict();
   end
endmodule
`default_nettype wire

// ### hdl/csoc_deglitch.sv
/*
 Deglitch filter for one overcurrent comparator.
 Assumes the level input is already synchronised to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module csoc_deglitch #(
   parameter int CYC = csoc_pkg::OCP_CYC
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic level,
   output var  logic tripped
);
   import csoc_pkg::*;
   localparam logic [15:0] LAST = 16'(CYC);
   logic [15:0] cnt;

   // The trip is raised only once the level has stayed high past the count.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt     <= '0;
         tripped <= 1'b0;
      end
      else
      begin
         if (!level)
            cnt <= '0;
         else if (cnt != LAST)
            cnt <= cnt + 16'h0001;
         tripped <= level && (cnt == LAST);
      end
   end
endmodule
`default_nettype wire

// ### hdl/csoc_pkg.sv
/*
 Shared constants and types for the current sense and overcurrent control block.
 Assumes a 100 MHz APB clock; register offsets are byte addresses.
*/
package csoc_pkg;
   ////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int CLK_NS    = 10;
   localparam int TRIP_DEGLITCH_TIME_NS  = 4000;
   localparam int OCP_CYC   = (TRIP_DEGLITCH_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int TRIM_US   = 100;
   localparam int TRIM_CYC  = (TRIM_US * 1000) / CLK_NS;
   ////////////////////////////////////////////////////////////////////
   // Register offsets.
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_CAL   = 8'h04;
   localparam logic [7:0] A_STATE = 8'h08;
   localparam logic [7:0] A_ISTAT = 8'h0C;
   localparam logic [7:0] A_IEN   = 8'h10;
   localparam logic [7:0] A_ICLR  = 8'h14;
   ////////////////////////////////////////////////////////////////////
   // Fields and reset values.
   localparam int CTRL_W    = 11;
   localparam int IRQ_W     = 9;
   localparam int IRQ_OCP   = 0;
   localparam int IRQ_TRIM  = 6;
   localparam logic [10:0] CTRL_RST = 11'h480;
   localparam logic [1:0] GAIN_40   = 2'h3;
   localparam logic [1:0] FM_LATCH  = 2'h0;
   localparam logic [1:0] FM_REPORT = 2'h1;
   // Control register; gain codes 0..3 are 5, 10, 20 and 40 V/V.
   typedef struct packed {
      logic [3:0] thr;
      logic [1:0] fmode;
      logic       fet_sel;
      logic       lowside_reference_select;
      logic       vdiv_off;
      logic [1:0] gain;
   } csoc_ctrl_t;
   // Analog switch controls of the three amplifiers.
   typedef struct packed {
      logic [5:0] gain;
      logic [2:0] short_in;
      logic [2:0] load_off;
      logic [2:0] enable;
   } csoc_amp_t;
   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_TRIM = 3'b010,
      CAL_HOLD = 3'b100
   } csoc_cal_t;
endpackage

// ### hdl/csoc_top.sv
/*
 Overcurrent monitors and current sense amplifier control with APB registers.
 Assumes comparator, calibrate and fault pin levels arrive asynchronously;
 low-side gate command and drive-time-done come from logic on pclk.
*/
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module csoc_top #(
   parameter int TRIM_CYCLES = csoc_pkg::TRIM_CYC
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [7:0]       paddr,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [31:0]      pwdata,
   output var  logic             pready,
   output var  logic [31:0]      prdata,
   output var  logic             pslverr,
   input  wire logic [2:0]       hs_cmp,
   input  wire logic [2:0]       ls_cmp_sp,
   input  wire logic [2:0]       ls_cmp_sn,
   input  wire logic             cal_pin,
   input  wire logic [2:0]       ls_gate_cmd,
   input  wire logic [2:0]       tdrive_done,
   input  wire logic             fault_out_n_i,
   output var  logic             fault_out_n_o,
   output var  logic             fault_out_n_oe,
   output var  logic             gate_shutdown,
   output var  logic [3:0]       trip_threshold,
   output var  logic             lowside_reference_select_sn,
   output var  logic             vref_bidir,
   output var  csoc_pkg::csoc_amp_t amp,
   output var  logic [2:0]       trim_run,
   output var  logic             irq
);
   import csoc_pkg::*;
   localparam logic [13:0] TRIM_LAST = 14'(TRIM_CYCLES - 1);

   // All checks in this module run on pclk and are off during reset.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////
   // Input synchronisers.
   logic [10:0] s1;
   logic [10:0] s2;
   logic [2:0]  hs_s;
   logic [2:0]  sp_s;
   logic [2:0]  sn_s;
   logic        cal_s;
   logic        fpin_s;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1 <= '0;
         s2 <= '0;
      end
      else
      begin
         s1 <= {fault_out_n_i, cal_pin, ls_cmp_sn, ls_cmp_sp, hs_cmp};
         s2 <= s1;
      end
   end

   assign hs_s   = s2[2:0];
   assign sp_s   = s2[5:3];
   assign sn_s   = s2[8:6];
   assign cal_s  = s2[9];
   assign fpin_s = s2[10];

   ////////////////////////////////////////////////////////////////////
   // Registers.
   csoc_ctrl_t       ctrl;
   csoc_ctrl_t       next_ctrl;
   logic [2:0]       cal_reg;
   logic [IRQ_W-1:0] stat;
   logic [IRQ_W-1:0] ien;
   logic [IRQ_W-1:0] set_ev;
   logic [IRQ_W-1:0] clr;
   logic             wr;
   logic             hit;
   logic [2:0]       cal_on;
   logic [2:0]       hold_on;
   logic             any_cal;
   logic [31:0]      next_rdata;

   assign wr = psel && penable && pwrite;
   assign hit = (paddr == A_CTRL) || (paddr == A_CAL) ||
                (paddr == A_STATE) || (paddr == A_ISTAT) ||
                (paddr == A_IEN) || (paddr == A_ICLR);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign any_cal = |cal_on;

   // Gain writes are held off during calibration so the old gain returns.
   always_comb
   begin
      next_ctrl = ctrl;
      if (wr && paddr == A_CTRL)
      begin
         next_ctrl = csoc_ctrl_t'(pwdata[CTRL_W-1:0]);
         if (any_cal)
            next_ctrl.gain = ctrl.gain;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl <= csoc_ctrl_t'(CTRL_RST);
      else
         ctrl <= next_ctrl;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cal_reg <= '0;
         ien     <= '0;
      end
      else if (wr)
      begin
         if (paddr == A_CAL)
            cal_reg <= pwdata[2:0];
         if (paddr == A_IEN)
            ien <= pwdata[IRQ_W-1:0];
      end
   end

   assign clr = (wr && paddr == A_ICLR) ? pwdata[IRQ_W-1:0] : '0;

   // A new event in the clearing cycle stays set.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stat <= '0;
      else
         stat <= (stat & ~clr) | set_ev;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(((stat & ~clr) | set_ev) & ien);
   end

   always_comb
   begin
      next_rdata = '0;
      case (paddr)
         A_CTRL:  next_rdata[CTRL_W-1:0] = ctrl;
         A_CAL:   next_rdata[2:0] = cal_reg;
         A_STATE: next_rdata[7:0] = {fpin_s, vref_bidir, hold_on, trim_run};
         A_ISTAT: next_rdata[IRQ_W-1:0] = stat;
         A_IEN:   next_rdata[IRQ_W-1:0] = ien;
         default: next_rdata = '0;
      endcase
   end

   // Read data is captured in the setup phase for a zero-wait access.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (psel && !penable && !pwrite)
         prdata <= next_rdata;
   end

   ////////////////////////////////////////////////////////////////////
   // Overcurrent monitors: three high side, three low side.
   logic [5:0] mon;
   logic [5:0] tripped;
   logic [5:0] trip_q;
   logic       use_sn;
   logic       next_fault;

   assign use_sn = ctrl.fet_sel || ctrl.lowside_reference_select;
   assign mon = {use_sn ? sn_s : sp_s, hs_s};

   generate
      for (genvar k = 0; k < 6; k++)
      begin : g_mon
         csoc_deglitch #(
            .CYC (OCP_CYC)
         ) u_dg (
            .pclk    (pclk),
            .presetn (presetn),
            .level   (mon[k]),
            .tripped (tripped[k])
         );
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trip_q <= '0;
      else
         trip_q <= tripped;
   end

   always_comb
   begin
      case (ctrl.fmode)
         FM_LATCH:  next_fault = |stat[IRQ_OCP +: 6];
         FM_REPORT: next_fault = |tripped;
         default:   next_fault = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fault_out_n_oe <= 1'b0;
         gate_shutdown  <= 1'b0;
      end
      else
      begin
         fault_out_n_oe <= next_fault;
         gate_shutdown  <= next_fault && ctrl.fmode == FM_LATCH;
      end
   end

   assign fault_out_n_o = 1'b0;

   ////////////////////////////////////////////////////////////////////
   // Offset calibration, one sequencer per amplifier.
   csoc_cal_t   st   [3];
   logic [13:0] tcnt [3];
   logic [2:0]  req;
   logic [2:0]  done_ev;

   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_cal
         assign req[i] = cal_reg[i] || cal_s;
         assign cal_on[i] = st[i] != CAL_IDLE;
         assign hold_on[i] = st[i] == CAL_HOLD;
         assign done_ev[i] = st[i] == CAL_TRIM && req[i] &&
                             tcnt[i] == TRIM_LAST;

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               st[i]   <= CAL_IDLE;
               tcnt[i] <= '0;
            end
            else
            begin
               case (st[i])
                  CAL_IDLE:
                  begin
                     tcnt[i] <= '0;
                     if (req[i])
                        st[i] <= CAL_TRIM;
                  end
                  CAL_TRIM:
                  begin
                     if (!req[i])
                        st[i] <= CAL_IDLE;
                     else if (done_ev[i])
                        st[i] <= CAL_HOLD;
                     else
                        tcnt[i] <= tcnt[i] + 14'h0001;
                  end
                  CAL_HOLD:
                  begin
                     if (!req[i])
                        st[i] <= CAL_IDLE;
                  end
                  default: st[i] <= CAL_IDLE;
               endcase
            end
         end

         a_trim_time: assert property (done_ev[i] |=> st[i] == CAL_HOLD)
            else $error("trim did not finish on its count");
         a_cal_force: assert property (cal_on[i] |=> amp.short_in[i] &&
            amp.load_off[i] && amp.gain[2*i +: 2] == GAIN_40)
            else $error("calibration did not force amplifier state");
         a_gain_back: assert property ((hold_on[i] && !req[i])
            |=> ##1 amp.gain[2*i +: 2] == $past(ctrl.gain))
            else $error("gain not restored after calibration");
      end
   endgenerate

   assign trim_run = {st[2] == CAL_TRIM, st[1] == CAL_TRIM,
                      st[0] == CAL_TRIM};
   assign set_ev = {done_ev,
                    (ctrl.fmode == FM_LATCH || ctrl.fmode == FM_REPORT) ?
                    (tripped & ~trip_q) : 6'h00};

   ////////////////////////////////////////////////////////////////////
   // Analog control outputs.
   csoc_amp_t next_amp;

   always_comb
   begin
      next_amp = '0;
      for (int i = 0; i < 3; i++)
      begin
         next_amp.gain[2*i +: 2] = cal_on[i] ? GAIN_40 : ctrl.gain;
         next_amp.load_off[i] = cal_on[i];
         next_amp.short_in[i] = cal_on[i] ||
            (ctrl.fet_sel && !ls_gate_cmd[i]);
         next_amp.enable[i] = cal_on[i] || !ctrl.fet_sel ||
            (tdrive_done[i] && ls_gate_cmd[i]);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         amp            <= '0;
         vref_bidir     <= 1'b1;
         lowside_reference_select_sn      <= 1'b0;
         trip_threshold <= CTRL_RST[10:7];
      end
      else
      begin
         amp            <= next_amp;
         vref_bidir     <= !ctrl.vdiv_off || any_cal;
         lowside_reference_select_sn      <= use_sn;
         trip_threshold <= ctrl.thr;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks.
   a_vref_force: assert property (any_cal |=> vref_bidir)
      else $error("reference not bidirectional during calibration");
   a_vref_uni: assert property ((ctrl.vdiv_off && !any_cal) |=> !vref_bidir)
      else $error("divider removal did not give unidirectional mode");
   a_ref_fet: assert property (ctrl.fet_sel |=> lowside_reference_select_sn)
      else $error("voltage sense mode did not pick sense negative");
   a_ref_sel: assert property ((!ctrl.fet_sel && !ctrl.lowside_reference_select) |=> !lowside_reference_select_sn)
      else $error("low side reference not sense positive");
   a_trip_drop: assert property (!mon[0] |=> !tripped[0])
      else $error("trip without a held level");
   a_trip_held: assert property ($rose(tripped[3]) |->
      $past(mon[3], 1) && $past(mon[3], 8))
      else $error("trip before deglitch time");
   a_fault_latch: assert property ((ctrl.fmode == FM_LATCH && |stat[5:0])
      |=> fault_out_n_oe && gate_shutdown)
      else $error("latched fault not driven");
   a_fet_short: assert property ((ctrl.fet_sel && !ls_gate_cmd[0])
      |=> amp.short_in[0])
      else $error("inputs not shorted with low side off");
endmodule
`default_nettype wire
